/* rtl/cfi_query_regs.svh */
`ifndef CFI_QUERY_REGS_SVH
`define CFI_QUERY_REGS_SVH

// query word addresses
`define QA_PROT_PTR0     9'h11D
`define QA_PROT_PTR1     9'h11E
`define QA_PROT_PTR2     9'h11F
`define QA_PROT_PTR3     9'h120
`define QA_FACT_GRP_LO   9'h121
`define QA_FACT_GRP_HI   9'h122
`define QA_FACT_SIZE     9'h123
`define QA_USER_GRP_LO   9'h124
`define QA_USER_GRP_HI   9'h125
`define QA_USER_SIZE     9'h126
`define QA_PAGE_CAP      9'h127
`define QA_SYNC_COUNT    9'h128
`define QA_SYNC_CFG1     9'h129
`define QA_SYNC_CFG2     9'h12A
`define QA_SYNC_CFG3     9'h12B

// query byte values
`define QV_PROT_PTR0     8'h89
`define QV_ZERO          8'h00
`define QV_USER_GRP_LO   8'h10
`define QV_USER_SIZE     8'h04
`define QV_PAGE_CAP      8'h00
`define QV_SYNC_COUNT    8'h03
`define QV_SYNC_CFG1     8'h02
`define QV_SYNC_CFG2     8'h03
`define QV_SYNC_CFG3     8'h07
`define QV_BURST_CONT    3'h7

// field layout of a capability byte
`define SYNC_CODE_MSB    2
`define SYNC_CODE_LSB    0

`endif

/* rtl/cfi_query_pkg.sv */
package cfi_query_pkg;

    typedef struct packed {
        logic        rd;
        logic [8:0]  addr;
    } query_req_s;

    typedef struct packed {
        logic        valid;
        logic        hit;
        logic [15:0] data;
    } query_rsp_s;

endpackage

/* rtl/cfi_query_rom.sv */
`timescale 1ns/1ps
`include "cfi_query_regs.svh"

// combinational lookup of the otp and burst query bytes
module cfi_query_rom
    import cfi_query_pkg::*;
(
    input  wire logic [8:0] i_addr,
    output logic            o_hit,
    output logic [7:0]      o_byte
);

    // address to byte table
    always_comb begin
        o_hit  = 1'b1;
        o_byte = `QV_ZERO;
        if (i_addr == `QA_PROT_PTR0) begin
            o_byte = `QV_PROT_PTR0;
        end else if (i_addr == `QA_PROT_PTR1 ||
                     i_addr == `QA_PROT_PTR2 ||
                     i_addr == `QA_PROT_PTR3) begin
            o_byte = `QV_ZERO;
        end else if (i_addr == `QA_FACT_GRP_LO ||
                     i_addr == `QA_FACT_GRP_HI) begin
            o_byte = `QV_ZERO;
        end else if (i_addr == `QA_FACT_SIZE) begin
            o_byte = `QV_ZERO;
        end else if (i_addr == `QA_USER_GRP_LO) begin
            o_byte = `QV_USER_GRP_LO;
        end else if (i_addr == `QA_USER_GRP_HI) begin
            o_byte = `QV_ZERO;
        end else if (i_addr == `QA_USER_SIZE) begin
            o_byte = `QV_USER_SIZE;
        end else if (i_addr == `QA_PAGE_CAP) begin
            o_byte = `QV_PAGE_CAP;
        end else if (i_addr == `QA_SYNC_COUNT) begin
            o_byte = `QV_SYNC_COUNT;
        end else if (i_addr == `QA_SYNC_CFG1) begin
            o_byte = `QV_SYNC_CFG1;
        end else if (i_addr == `QA_SYNC_CFG2) begin
            o_byte = `QV_SYNC_CFG2;
        end else if (i_addr == `QA_SYNC_CFG3) begin
            o_byte = `QV_SYNC_CFG3;
        end else begin
            o_hit = 1'b0;
        end
    end

endmodule

/* rtl/cfi_query_otp_burst_info.sv */
// What this block does
// - protection lock pointer: four bytes, 89h then three zeros
// - factory group count low and high bytes both read zero
// - factory size exponent byte reads zero
// - user group count reads 10h low, 00h high
// - user bytes per group byte reads 04h, sixteen bytes
// - page mode capability byte reads zero, no page buffer
// - synchronous configuration field count reads three
// - capability code in bits 0-2, upper bits reserved; first reads 02h
// - second capability field reads 03h, sixteen words
// - third capability field reads 07h, continuous burst
`timescale 1ns/1ps
`include "cfi_query_regs.svh"

module cfi_query_otp_burst_info
    import cfi_query_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_query_mode,
    input  wire logic        i_rd,
    input  wire logic [8:0]  i_addr,
    output logic             o_valid,
    output logic             o_hit,
    output logic [15:0]      o_data,
    output logic [15:0]      o_burst_words,
    output logic             o_burst_cont
);

    query_req_s req;
    query_rsp_s rsp_q;
    logic       rom_hit;
    logic [7:0] rom_byte;
    logic [2:0] code_sel;

    assign req = '{rd: i_rd & i_query_mode, addr: i_addr};

    cfi_query_rom u_rom (
        .i_addr (req.addr),
        .o_hit  (rom_hit),
        .o_byte (rom_byte)
    );

    // burst length decode of a capability code
    function automatic logic [15:0] burst_len(input logic [2:0] code);
        burst_len = 16'h0000;
        if (code != `QV_BURST_CONT) begin
            burst_len = 16'h0001 << (code + 3'h1);
        end
    endfunction

    // true for the three capability field addresses
    function automatic logic is_cap_addr(input logic [8:0] addr);
        is_cap_addr = (addr == `QA_SYNC_CFG1) ||
                      (addr == `QA_SYNC_CFG2) ||
                      (addr == `QA_SYNC_CFG3);
    endfunction

    assign code_sel = rom_byte[`SYNC_CODE_MSB:`SYNC_CODE_LSB];

    // read answer, one cycle after the request
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rsp_q <= '0;
        end else begin
            rsp_q.valid <= req.rd;
            rsp_q.hit   <= req.rd & rom_hit;
            if (req.rd && rom_hit) begin
                rsp_q.data <= {8'h00, rom_byte};
            end else begin
                rsp_q.data <= 16'h0000;
            end
        end
    end

    // decoded burst length of the capability byte last read
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_burst_words <= 16'h0000;
            o_burst_cont  <= 1'b0;
        end else if (req.rd && rom_hit && is_cap_addr(req.addr)) begin
            o_burst_words <= burst_len(code_sel);
            o_burst_cont  <= (code_sel == `QV_BURST_CONT);
        end
    end

    // registered answer onto the output pins
    assign o_valid = rsp_q.valid;
    assign o_hit   = rsp_q.hit;
    assign o_data  = rsp_q.data;

    // answer framing: one pulse per taken read, quiet otherwise
    valid_pulse_a: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        req.rd |=> o_valid)
        else $error("taken read gave no answer");

    idle_quiet_a: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        !req.rd |=> !o_valid && !o_hit && o_data == 16'h0000)
        else $error("answer without a taken read");

    mode_gate_a: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        !i_query_mode |=> !o_valid)
        else $error("answer while not in query mode");

    no_query_a: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        (i_rd && !i_query_mode) |=> !o_valid && o_data == 16'h0000)
        else $error("answer outside query mode");

    upper_zero_a: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        o_valid |-> o_data[15:8] == 8'h00)
        else $error("upper data lines not zero");

    hit_valid_a: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        o_hit |-> o_valid)
        else $error("hit without valid");

    miss_zero_a: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        (o_valid && !o_hit) |-> o_data == 16'h0000)
        else $error("miss returned data");

    outside_miss_a: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        (req.rd && (i_addr < `QA_PROT_PTR0 || i_addr > `QA_SYNC_CFG3))
        |=> o_valid && !o_hit)
        else $error("address outside table hit");

    inside_hit_a: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        (req.rd && i_addr >= `QA_PROT_PTR0 && i_addr <= `QA_SYNC_CFG3)
        |=> o_valid && o_hit)
        else $error("address inside table missed");

    // protection and otp fields
    prot_ptr_a: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        (req.rd && i_addr == `QA_PROT_PTR0) |=> o_hit && o_data == 16'h0089)
        else $error("lock pointer low byte wrong");

    prot_zero_a: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        (req.rd && i_addr >= `QA_PROT_PTR1 && i_addr <= `QA_PROT_PTR3)
        |=> o_hit && o_data == 16'h0000)
        else $error("lock pointer upper byte not zero");

    prot_hi_a: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        (req.rd && i_addr >= `QA_PROT_PTR1 && i_addr <= `QA_FACT_SIZE)
        |=> o_hit && o_data == 16'h0000)
        else $error("pointer or factory byte not zero");

    fact_grp_a: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        (req.rd && (i_addr == `QA_FACT_GRP_LO || i_addr == `QA_FACT_GRP_HI))
        |=> o_hit && o_data == 16'h0000)
        else $error("factory group count not zero");

    fact_size_a: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        (req.rd && i_addr == `QA_FACT_SIZE) |=> o_hit && o_data == 16'h0000)
        else $error("factory size exponent not zero");

    user_grp_a: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        (req.rd && i_addr == `QA_USER_GRP_LO) |=> o_hit && o_data == 16'h0010)
        else $error("user group count wrong");

    user_hi_a: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        (req.rd && i_addr == `QA_USER_GRP_HI) |=> o_hit && o_data == 16'h0000)
        else $error("user group count high byte wrong");

    user_size_a: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        (req.rd && i_addr == `QA_USER_SIZE) |=> o_hit && o_data == 16'h0004)
        else $error("user group size wrong");

    // burst read capability table
    page_cap_a: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        (req.rd && i_addr == `QA_PAGE_CAP) |=> o_hit && o_data == 16'h0000)
        else $error("page capability wrong");

    sync_cnt_a: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        (req.rd && i_addr == `QA_SYNC_COUNT) |=> o_hit && o_data == 16'h0003)
        else $error("sync field count wrong");

    burst_eight_a: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        (req.rd && i_addr == `QA_SYNC_CFG1)
        |=> o_data == 16'h0002 && o_burst_words == 16'h0008)
        else $error("first burst field wrong");

    cap_reserved_a: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        (req.rd && is_cap_addr(i_addr)) |=> o_data[7:3] == 5'h00)
        else $error("reserved capability bits set");

    burst_sixteen_a: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        (req.rd && i_addr == `QA_SYNC_CFG2)
        |=> o_data == 16'h0003 && o_burst_words == 16'h0010)
        else $error("second burst field wrong");

    burst_cont_a: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        (req.rd && i_addr == `QA_SYNC_CFG3)
        |=> o_data == 16'h0007 && o_burst_cont)
        else $error("third burst field wrong");

    // decoded burst length outputs
    cont_words_a: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        o_burst_cont |-> o_burst_words == 16'h0000)
        else $error("continuous burst with a length");

    cont_clear_a: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        (req.rd && (i_addr == `QA_SYNC_CFG1 || i_addr == `QA_SYNC_CFG2))
        |=> !o_burst_cont)
        else $error("fixed burst flagged continuous");

    words_pow_a: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        !o_burst_cont |-> $onehot0(o_burst_words) && !o_burst_words[0])
        else $error("burst length not a power of two");

    burst_hold_a: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        !(req.rd && is_cap_addr(i_addr))
        |=> $stable(o_burst_words) && $stable(o_burst_cont))
        else $error("burst decode changed without a read");

endmodule

/* bench/query_host_model.sv */
`timescale 1ns/1ps
// host controller side: issues query reads on the falling edge
module query_host_model (
    input  wire logic        i_sys_clk,
    input  wire logic        i_valid,
    input  wire logic        i_hit,
    input  wire logic [15:0] i_data,
    output logic             o_query_mode,
    output logic             o_rd,
    output logic [8:0]       o_addr
);
    logic [2:0] read_config_register = 3'h0;
    initial begin
        o_query_mode = 1'b0;
        o_rd = 1'b0;
        o_addr = 9'h000;
    end
    // one read, answer sampled on the falling edge half a cycle after it is taken
    task automatic read(input logic [8:0] a, input logic m,
        output logic v, output logic h, output logic [15:0] d);
        @(negedge i_sys_clk);
        o_query_mode = m;
        o_rd = 1'b1;
        o_addr = a;
        @(negedge i_sys_clk);
        o_rd = 1'b0;
        o_addr = ~a; // released address does not keep its value
        v = i_valid;
        h = i_hit;
        d = i_data;
        // burst code copied as is, host runs at max word width
        if (v && h && a >= 9'h129 && a <= 9'h12B) begin
            read_config_register = d[2:0];
        end
    endtask
endmodule

/* bench/cfi_query_otp_burst_info_tb_top.sv */
`timescale 1ns/1ps
module cfi_query_otp_burst_info_tb_top;
    logic        i_sys_clk = 1'b0;
    logic        i_rst_b = 1'b0;
    logic        q_mode, rd, o_valid, o_hit, o_burst_cont;
    logic [8:0]  addr;
    logic [15:0] o_data, o_burst_words;
    int          errors = 0;
    int          n_tests = 0;
    int          cycles = 0;
    logic [7:0]  exp_b [15] = '{8'h89, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h10, 8'h00, 8'h04, 8'h00, 8'h03, 8'h02,
        8'h03, 8'h07};
    always #12.5 i_sys_clk = ~i_sys_clk;
    cfi_query_otp_burst_info u_dut (.i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b), .i_query_mode(q_mode), .i_rd(rd),
        .i_addr(addr), .o_valid(o_valid), .o_hit(o_hit),
        .o_data(o_data), .o_burst_words(o_burst_words),
        .o_burst_cont(o_burst_cont));
    query_host_model u_host (.i_sys_clk(i_sys_clk), .i_valid(o_valid),
        .i_hit(o_hit), .i_data(o_data), .o_query_mode(q_mode),
        .o_rd(rd), .o_addr(addr));
    // compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // every location, one read every other cycle, whole word with the upper byte zero
    task automatic t_table();
        logic v, h;
        logic [15:0] d;
        for (int i = 0; i < 15; i++) begin
            u_host.read(9'h11D + 9'(i), 1'b1, v, h, d);
            check({14'h0000, v, h}, 16'h0003);
            if (i < 7) check(d, {8'h00, exp_b[i]});
            else check(d, {8'h00, exp_b[i]});
        end
    endtask
    // outside query mode and outside the table
    task automatic t_refuse();
        logic v, h;
        logic [15:0] d;
        u_host.read(9'h11D, 1'b0, v, h, d);
        check({15'h0000, v}, 16'h0000);
        check(d, 16'h0000);
        u_host.read(9'h12C, 1'b1, v, h, d);
        check({14'h0000, v, h}, 16'h0002);
        check(d, 16'h0000);
    endtask
    // burst code decode of each capability field
    task automatic t_burst();
        logic v, h;
        logic [15:0] d;
        logic [15:0] words [3] = '{16'h0008, 16'h0010, 16'h0000};
        for (int i = 0; i < 3; i++) begin
            u_host.read(9'h129 + 9'(i), 1'b1, v, h, d);
            check(o_burst_words, words[i]);
            check({15'h0000, o_burst_cont}, {15'h0000, i == 2});
        end
        u_host.read(9'h11D, 1'b0, v, h, d);
        check({15'h0000, o_burst_cont}, 16'h0001);
        check({13'h0000, u_host.read_config_register}, 16'h0007);
    endtask
    // burst decode holds, then a mid-run reset clears every output
    task automatic t_reset();
        logic v, h;
        logic [15:0] d;
        u_host.read(9'h129, 1'b1, v, h, d);
        check(o_burst_words, 16'h0008);
        u_host.read(9'h124, 1'b1, v, h, d);
        check(d, 16'h0010);
        check(o_burst_words, 16'h0008);
        i_rst_b = 1'b0;
        @(negedge i_sys_clk);
        check({13'h0000, o_valid, o_hit, o_burst_cont}, 16'h0000);
        check(o_data, 16'h0000);
        check(o_burst_words, 16'h0000);
        @(negedge i_sys_clk);
        i_rst_b = 1'b1;
        @(negedge i_sys_clk);
        check({13'h0000, o_valid, o_hit, o_burst_cont}, 16'h0000);
        check(o_burst_words, 16'h0000);
        u_host.read(9'h12A, 1'b1, v, h, d);
        check(d, 16'h0003);
        check(o_burst_words, 16'h0010);
    endtask
    // hang guard
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            test_done();
        end
    end
    initial begin
        repeat (6) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        i_rst_b = 1'b1;
        t_table();
        t_refuse();
        t_burst();
        t_reset();
        test_done();
    end
endmodule
